/* logic/lrsd_controller.sv */
`timescale 1ns/100ps
`default_nettype none

module lrsd_controller
  import lrsd_pkg::*;
(
  input wire logic clock, // Interface clock, rising edge sampled.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [1:0] interface_control_pair, // Control pair from the device.
  input wire logic cmd_valid, // Command request.
  output logic cmd_ready, // Command taken this cycle.
  input wire logic [2:0] cmd_type, // Request type code.
  input wire logic [2:0] cmd_speed, // Speed code for bus requests.
  input wire logic cmd_short, // Omit the optional stop bit.
  input wire logic [3:0] cmd_addr, // Register address.
  input wire logic [7:0] cmd_data, // Write data.
  input wire logic cmd_accel_on, // Acceleration control value.
  input wire logic cycle_start_seen, // Pulse: a cycle start was sent or received.
  input wire logic bus_reset, // Pulse: bus reset observed.
  input wire logic header_crc_bad, // Level: received header failed its check.
  output logic link_request_line, // Serial request line to the device.
  output logic ctl_out, // Hold/idle drive toward the control pair after grant.
  output logic [1:0] ctl_drive, // Control value driven while owning the pair.
  output logic ctl_oe, // High while this end drives the control pair.
  output logic bus_pending, // A bus request is outstanding.
  output logic read_pending, // A register read awaits its status transfer.
  input wire logic read_answered, // Pulse: register contents arrived.
  output logic frame_dropped // Pulse: fair/priority frame cut by receive.
);

  lrsd_state_t state_q, state_d;
  logic [16:0] image;
  logic [4:0] length;
  logic load, abort, busy, done;
  logic is_bus, is_fp, fp_q, fp_d;
  logic [1:0] ctl_prev_q;
  logic bus_q, bus_d, read_q, read_d, iso_ok_q, iso_ok_d;
  logic drop_q, drop_d, own_q, own_d;
  logic pend_fp_q, pend_fp_d;
  logic was_idle;
  logic accept;

  // ***************************************************************
  // Frame assembly.
  // ***************************************************************
  // The image is left aligned so one shifter serves every length.
  always_comb begin
    image = '0;
    image[LRSD_POS_START] = 1'b1;
    image[LRSD_POS_TYPE_HI -: 3] = cmd_type;
    length = LRSD_LEN_BUS;
    case (cmd_type)
      LRSD_TYPE_REG_READ: begin
        image[LRSD_POS_FIELD_HI -: 4] = cmd_addr;
        length = LRSD_LEN_READ;
      end
      LRSD_TYPE_REG_WRITE: begin
        image[LRSD_POS_FIELD_HI -: 12] = {cmd_addr, cmd_data};
        length = LRSD_LEN_WRITE;
      end
      LRSD_TYPE_ACCEL: begin
        image[LRSD_POS_FIELD_HI] = cmd_accel_on;
        length = LRSD_LEN_ACCEL;
      end
      default: begin
        // Invalid speed codes still go out; the device answers them with a null packet.
        image[LRSD_POS_FIELD_HI -: 3] = cmd_speed;
        // Short form only legal when the last speed bit is zero.
        length = (cmd_short && !cmd_speed[0]) ? LRSD_LEN_BUS_SHORT : LRSD_LEN_BUS;
      end
    endcase
  end

  // ***************************************************************
  // Acceptance checks.
  // ***************************************************************
  assign is_bus = (cmd_type[2] == 1'b0);
  assign is_fp = (cmd_type == LRSD_TYPE_PRIORITY) || (cmd_type == LRSD_TYPE_FAIR);
  // Idle must have been seen a clock earlier before fair/priority starts.
  assign was_idle = (ctl_prev_q == LRSD_CTL_IDLE) && (interface_control_pair == LRSD_CTL_IDLE);
  // Reserved codes are refused here so the device never sees them.
  always_comb begin
    accept = cmd_valid && (state_q == LRSD_ST_IDLE) && !busy && !own_q;
    if (cmd_type == LRSD_TYPE_RESERVED) begin
      accept = 1'b0;
    end else if (is_bus && bus_q) begin
      accept = 1'b0;
    end else if (cmd_type == LRSD_TYPE_REG_READ && read_q) begin
      accept = 1'b0;
    end else if (cmd_type == LRSD_TYPE_ISOCHRONOUS && !iso_ok_q) begin
      accept = 1'b0;
    end else if (is_fp && !was_idle) begin
      accept = 1'b0;
    end else if (cmd_type == LRSD_TYPE_IMMEDIATE && interface_control_pair != LRSD_CTL_RECEIVE) begin
      accept = 1'b0;
    end
  end
  assign cmd_ready = accept;
  assign load = accept;
  // A receive during a fair/priority frame makes the device ignore it.
  assign abort = fp_q && busy && (interface_control_pair == LRSD_CTL_RECEIVE);

  lrsd_shifter u_shifter (
    .clock(clock),
    .rst(rst),
    .load(load),
    .abort(abort),
    .image(image),
    .length(length),
    .line_out(link_request_line),
    .busy(busy),
    .done(done)
  );

  // ***************************************************************
  // Sequencer and request bookkeeping.
  // ***************************************************************
  // Mirrors the device's pending state so no second bus request goes out.
  always_comb begin
    state_d = state_q;
    fp_d = fp_q;
    bus_d = bus_q;
    read_d = read_q;
    iso_ok_d = iso_ok_q;
    drop_d = 1'b0;
    own_d = own_q;
    pend_fp_d = pend_fp_q;
    case (state_q)
      LRSD_ST_IDLE: begin
        if (accept) begin
          state_d = LRSD_ST_SEND;
          fp_d = is_fp;
          // The pending kind is kept apart from the frame kind, so a later read or write
          // frame does not hide a pending fair or priority request from the receive clear.
          if (is_bus) begin
            bus_d = 1'b1;
            pend_fp_d = is_fp;
          end
          if (cmd_type == LRSD_TYPE_REG_READ) begin
            read_d = 1'b1;
          end
        end
      end
      LRSD_ST_SEND: begin
        if (abort) begin
          state_d = LRSD_ST_IDLE;
          bus_d = 1'b0;
          drop_d = 1'b1;
        end else if (done) begin
          state_d = LRSD_ST_WAIT;
        end
      end
      default: begin
        state_d = LRSD_ST_IDLE;
      end
    endcase
    if (bus_q && pend_fp_q && !(busy && fp_q) && interface_control_pair == LRSD_CTL_RECEIVE) begin
      bus_d = 1'b0;
    end
    if (bus_q && interface_control_pair == LRSD_CTL_GRANT) begin
      bus_d = 1'b0;
      own_d = 1'b1;
    end
    if (own_q && (header_crc_bad || interface_control_pair != LRSD_CTL_GRANT)) begin
      own_d = 1'b0;
    end
    if (bus_reset) begin
      bus_d = 1'b0;
      iso_ok_d = 1'b0;
    end
    if (cycle_start_seen) begin
      iso_ok_d = 1'b1;
    end
    // Set wins over the answer arriving in the same cycle.
    if (read_q && read_answered && !(accept && cmd_type == LRSD_TYPE_REG_READ)) begin
      read_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= LRSD_ST_IDLE;
      fp_q <= 1'b0;
      bus_q <= 1'b0;
      read_q <= 1'b0;
      iso_ok_q <= 1'b0;
      drop_q <= 1'b0;
      own_q <= 1'b0;
      pend_fp_q <= 1'b0;
      ctl_prev_q <= LRSD_CTL_IDLE;
    end else begin
      state_q <= state_d;
      fp_q <= fp_d;
      bus_q <= bus_d;
      read_q <= read_d;
      iso_ok_q <= iso_ok_d;
      drop_q <= drop_d;
      own_q <= own_d;
      pend_fp_q <= pend_fp_d;
      ctl_prev_q <= interface_control_pair;
    end
  end

  // ***************************************************************
  // Outputs. The grant is only released here; packet sending is elsewhere.
  // ***************************************************************
  assign ctl_oe = own_q && !header_crc_bad;
  assign ctl_drive = LRSD_CTL_IDLE;
  assign ctl_out = 1'b0;
  assign bus_pending = bus_q;
  assign read_pending = read_q;
  assign frame_dropped = drop_q;

endmodule

`default_nettype wire

/* logic/lrsd_pkg.sv */
package lrsd_pkg;

  // ***************************************************************
  // Request type codes, three bits, sent first after the start bit.
  // ***************************************************************
  localparam logic [2:0] LRSD_TYPE_IMMEDIATE = 3'h0;
  localparam logic [2:0] LRSD_TYPE_ISOCHRONOUS = 3'h1;
  localparam logic [2:0] LRSD_TYPE_PRIORITY = 3'h2;
  localparam logic [2:0] LRSD_TYPE_FAIR = 3'h3;
  localparam logic [2:0] LRSD_TYPE_REG_READ = 3'h4;
  localparam logic [2:0] LRSD_TYPE_REG_WRITE = 3'h5;
  localparam logic [2:0] LRSD_TYPE_ACCEL = 3'h6;
  localparam logic [2:0] LRSD_TYPE_RESERVED = 3'h7;

  // ***************************************************************
  // Speed codes for bus requests.
  // ***************************************************************
  localparam logic [2:0] LRSD_SPEED_S100 = 3'h0;
  localparam logic [2:0] LRSD_SPEED_S200 = 3'h2;
  localparam logic [2:0] LRSD_SPEED_S400 = 3'h4;

  // ***************************************************************
  // Frame lengths in bits, start bit included, stop bit included in all but the short bus form.
  // ***************************************************************
  localparam logic [4:0] LRSD_LEN_BUS_SHORT = 5'h07;
  localparam logic [4:0] LRSD_LEN_BUS = 5'h08;
  localparam logic [4:0] LRSD_LEN_READ = 5'h09;
  localparam logic [4:0] LRSD_LEN_WRITE = 5'h11;
  localparam logic [4:0] LRSD_LEN_ACCEL = 5'h06;

  // ***************************************************************
  // Field positions in the 17-bit left-aligned frame image.
  // Frame bit 0 sits at image bit 16.
  // ***************************************************************
  localparam int LRSD_FRAME_W = 17;
  localparam int LRSD_POS_START = 16;
  localparam int LRSD_POS_TYPE_HI = 15;
  localparam int LRSD_POS_FIELD_HI = 12;

  // ***************************************************************
  // Control pair codes while the device owns it.
  // ***************************************************************
  localparam logic [1:0] LRSD_CTL_IDLE = 2'h0;
  localparam logic [1:0] LRSD_CTL_STATUS = 2'h1;
  localparam logic [1:0] LRSD_CTL_RECEIVE = 2'h2;
  localparam logic [1:0] LRSD_CTL_GRANT = 2'h3;

  // Controller sequencer states, Gray coded from idle through send to wait.
  typedef enum logic [1:0] {
    LRSD_ST_IDLE = 2'b00,
    LRSD_ST_SEND = 2'b01,
    LRSD_ST_WAIT = 2'b11
  } lrsd_state_t;

endpackage

/* logic/lrsd_shifter.sv */
`timescale 1ns/100ps
`default_nettype none

// Serialiser: loads a left-aligned frame image and shifts it out MSB first.
module lrsd_shifter
  import lrsd_pkg::*;
(
  input wire logic clock, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic load, // Load a new frame image.
  input wire logic abort, // Drop the frame in flight.
  input wire logic [16:0] image, // Frame image, frame bit 0 at the top.
  input wire logic [4:0] length, // Bits in the frame.
  output logic line_out, // Serial request line.
  output logic busy, // Frame in flight.
  output logic done // Pulse on the cycle after the last bit.
);

  logic [16:0] sr_q, sr_d;
  logic [4:0] left_q, left_d;
  logic done_q, done_d;

  // ***************************************************************
  // Shift register; the line reads zero when nothing is left.
  // ***************************************************************
  always_comb begin
    sr_d = sr_q;
    left_d = left_q;
    done_d = 1'b0;
    if (load) begin
      sr_d = image;
      left_d = length;
    end else if (abort) begin
      sr_d = '0;
      left_d = '0;
    end else if (left_q != 5'h00) begin
      sr_d = {sr_q[15:0], 1'b0};
      left_d = left_q - 5'h01;
      done_d = (left_q == 5'h01);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sr_q <= '0;
      left_q <= '0;
      done_q <= 1'b0;
    end else begin
      sr_q <= sr_d;
      left_q <= left_d;
      done_q <= done_d;
    end
  end

  // Held low outside frames; masking by the count keeps the line quiet. 
  assign line_out = (left_q != 5'h00) & sr_q[LRSD_POS_START];
  assign busy = (left_q != 5'h00);
  assign done = done_q;

endmodule

`default_nettype wire

/* verification/lrsd_device_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************
// Device model: decodes request frames and plays the control pair.
// ****************
module lrsd_device_model
  import lrsd_pkg::*;
(
  input wire logic clock, // Interface clock.
  input wire logic rst, // Reset.
  input wire logic link_request_line, // Requests in.
  input wire logic ctl_oe, // Controller drives the pair.
  input wire logic [1:0] ctl_set, // Pair code asked by the bench.
  output logic [1:0] interface_control_pair, // Pair code shown.
  output logic [16:0] frame_q, // Last frame, right aligned.
  output logic frame_done // Frame complete.
);
  logic [4:0] count_q, flen;
  logic [2:0] typ;
  logic imm_q, gnt_q, oe_q;
  // A bus frame is always read as 8 bits: an omitted stop bit looks like the low idle line.
  always_comb begin
    typ = 3'(frame_q >> (count_q - 5'h04));
    case (typ)
      LRSD_TYPE_REG_READ: flen = LRSD_LEN_READ;
      LRSD_TYPE_REG_WRITE: flen = LRSD_LEN_WRITE;
      LRSD_TYPE_ACCEL: flen = LRSD_LEN_ACCEL;
      default: flen = LRSD_LEN_BUS;
    endcase
  end
  // Grant overrides the bench code while an immediate grant is held.
  assign interface_control_pair = gnt_q ? LRSD_CTL_GRANT : ctl_set;
  // Frame capture and grant handling on the rising edge.
  always_ff @(posedge clock) begin
    frame_done <= 1'b0;
    oe_q <= ctl_oe;
    if (rst) begin
      count_q <= 5'h00;
      imm_q <= 1'b0;
      gnt_q <= 1'b0;
    end else begin
      if (count_q == 5'h00) begin
        if (link_request_line) begin
          count_q <= 5'h01;
          frame_q <= 17'h00001;
        end
      end else begin
        frame_q <= {frame_q[15:0], link_request_line};
        count_q <= (count_q + 5'h01 == flen) ? 5'h00 : count_q + 5'h01;
        frame_done <= (count_q + 5'h01 == flen);
        imm_q <= imm_q || (count_q + 5'h01 == flen && typ == LRSD_TYPE_IMMEDIATE);
      end
      if (gnt_q) begin
        gnt_q <= !(oe_q && !ctl_oe);
      end else if (imm_q && ctl_set == LRSD_CTL_IDLE) begin
        gnt_q <= 1'b1;
        imm_q <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

/* verification/lrsd_monitor.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************
// Port checker for the request sequencer.
// ****************
module lrsd_monitor
  import lrsd_pkg::*;
(
  input wire logic clock, // Clock.
  input wire logic rst, // Reset.
  input wire logic [1:0] interface_control_pair, // Pair.
  input wire logic cmd_valid, // Offer.
  input wire logic cmd_ready, // Taken.
  input wire logic [2:0] cmd_type, // Type.
  input wire logic [7:0] cmd_data, // Data.
  input wire logic cmd_accel_on, // Accel bit.
  input wire logic header_crc_bad, // Bad CRC.
  input wire logic link_request_line, // Line.
  input wire logic ctl_oe, // Pair drive.
  input wire logic bus_pending, // Bus pending.
  input wire logic read_pending // Read pending.
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic take;
  // Every frame check starts from the handshake edge.
  assign take = cmd_valid && cmd_ready;
  // Start bit, then the type code from its top bit down.
  sequence head_s;
    link_request_line ##1 (link_request_line == $past(cmd_type[2], 2)) ##1
      (link_request_line == $past(cmd_type[1], 3)) ##1 (link_request_line == $past(cmd_type[0], 4));
  endsequence
  frame_head_a: assert property (take |=> head_s)
    else $error("bad frame head");
  accel_frame_a: assert property (take && cmd_type == LRSD_TYPE_ACCEL |-> ##5
    (link_request_line == $past(cmd_accel_on, 5)) ##1 !link_request_line) else $error("bad accel frame");
  write_frame_a: assert property (take && cmd_type == LRSD_TYPE_REG_WRITE |-> ##9
    (link_request_line == $past(cmd_data[7], 9)) ##8 !link_request_line) else $error("bad write frame");
  reserved_type_a: assert property (cmd_type == LRSD_TYPE_RESERVED |-> !cmd_ready)
    else $error("reserved type taken");
  one_bus_a: assert property (bus_pending && !cmd_type[2] |-> !cmd_ready)
    else $error("second bus request taken");
  one_read_a: assert property (read_pending && cmd_type == LRSD_TYPE_REG_READ |-> !cmd_ready)
    else $error("second read taken");
  crc_release_a: assert property (header_crc_bad |-> !ctl_oe)
    else $error("grant kept on bad CRC");
  fair_gap_a: assert property (take && cmd_type[2:1] == 2'h1 |-> interface_control_pair == LRSD_CTL_IDLE &&
    $past(interface_control_pair) == LRSD_CTL_IDLE) else $error("fair or priority too early");
endmodule

bind lrsd_controller lrsd_monitor u_lrsd_monitor (.clock, .rst, .interface_control_pair, .cmd_valid, .cmd_ready,
  .cmd_type, .cmd_data, .cmd_accel_on, .header_crc_bad, .link_request_line, .ctl_oe, .bus_pending, .read_pending);

`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/100ps
`default_nettype none

// ****************
// Bench: drives commands, the device model decodes the line.
// ****************
module tb
  import lrsd_pkg::*;
;
  logic clock, rst, cmd_valid, cmd_ready, cmd_short, cmd_accel_on, cycle_start_seen, bus_reset, header_crc_bad;
  logic read_answered, link_request_line, ctl_oe, bus_pending, read_pending, frame_dropped, frame_done, ctl_out;
  logic [2:0] cmd_type, cmd_speed;
  logic [3:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [1:0] ctl_set, interface_control_pair, ctl_drive;
  logic [16:0] frame_q;
  int mismatches, n_compared;
  lrsd_controller u_lrsd_controller (.clock, .rst, .interface_control_pair, .cmd_valid, .cmd_ready, .cmd_type,
    .cmd_speed, .cmd_short, .cmd_addr, .cmd_data, .cmd_accel_on, .cycle_start_seen, .bus_reset, .header_crc_bad,
    .link_request_line, .ctl_out, .ctl_drive, .ctl_oe, .bus_pending, .read_pending, .read_answered, .frame_dropped);
  lrsd_device_model u_lrsd_device_model (.clock, .rst, .link_request_line, .ctl_oe, .ctl_set,
    .interface_control_pair, .frame_q, .frame_done);
  // Clock of 20 ns period.
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [16:0] got, input logic [16:0] want);
    n_compared++;
    if (got !== want) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Hold one command until taken; ready is read at the falling edge, where it has settled.
  task automatic offer(input logic [2:0] t, input logic [2:0] s, input logic [3:0] a, input logic [7:0] d);
    cmd_type <= t;
    cmd_speed <= s;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_accel_on <= a[0];
    cmd_valid <= 1'b1;
    repeat (40) begin
      @(negedge clock);
      if (cmd_ready === 1'b1) break;
    end
    check(17'(cmd_ready), 17'h00001);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  // Offer, then compare the frame the device decoded with one built from the field layout.
  task automatic send(input logic [2:0] t, input logic [2:0] s, input logic [3:0] a, input logic [7:0] d);
    offer(t, s, a, d);
    repeat (30) begin
      @(negedge clock);
      if (frame_done === 1'b1) break;
    end
    case (t)
      LRSD_TYPE_REG_READ: check(frame_q, {8'h00, 1'b1, t, a, 1'b0});
      LRSD_TYPE_REG_WRITE: check(frame_q, {1'b1, t, a, d, 1'b0});
      LRSD_TYPE_ACCEL: check(frame_q, {11'h000, 1'b1, t, a[0], 1'b0});
      default: check(frame_q, {9'h000, 1'b1, t, s, 1'b0});
    endcase
    @(posedge clock);
  endtask
  // Offer a command that must stay refused for several cycles.
  task automatic refuse(input logic [2:0] t);
    logic seen;
    seen = 1'b0;
    cmd_type <= t;
    cmd_valid <= 1'b1;
    repeat (6) begin
      @(negedge clock);
      // The line must also stay quiet while nothing is taken.
      seen = seen | cmd_ready | link_request_line;
    end
    check(17'(seen), 17'h00000);
    @(posedge clock);
    cmd_valid <= 1'b0;
  endtask
  task automatic reg_requests();
    send(LRSD_TYPE_REG_READ, 3'h0, 4'hA, 8'h00);
    refuse(LRSD_TYPE_REG_READ);
    send(LRSD_TYPE_REG_WRITE, 3'h0, 4'h5, 8'hC3);
    read_answered <= 1'b1;
    @(posedge clock);
    read_answered <= 1'b0;
    @(negedge clock);
    check(17'(read_pending), 17'h00000);
    @(posedge clock);
    send(LRSD_TYPE_ACCEL, 3'h0, 4'h1, 8'h00);
    send(LRSD_TYPE_ACCEL, 3'h0, 4'h0, 8'h00);
    refuse(LRSD_TYPE_RESERVED);
  endtask
  // Isochronous, priority and fair at each speed; receive must clear fair and priority but keep isochronous.
  task automatic bus_requests();
    logic [2:0] sp [4] = '{3'h0, 3'h2, 3'h4, 3'h7};
    for (int t = 1; t < 4; t++) begin
      foreach (sp[i]) begin
        cycle_start_seen <= 1'b1;
        @(posedge clock);
        cycle_start_seen <= 1'b0;
        send(3'(t), sp[i], 4'h0, 8'h00);
        refuse(3'(t));
        ctl_set <= LRSD_CTL_RECEIVE;
        @(posedge clock);
        ctl_set <= LRSD_CTL_IDLE;
        @(negedge clock);
        check(17'(bus_pending), 17'(t == 1));
        @(posedge clock);
        bus_reset <= 1'b1;
        @(posedge clock);
        bus_reset <= 1'b0;
        @(negedge clock);
        check(17'(bus_pending), 17'h00000);
        @(posedge clock);
      end
    end
  endtask
  // A fair request cut by a receive code in mid-frame.
  task automatic dropped_request();
    offer(LRSD_TYPE_FAIR, 3'h4, 4'h0, 8'h00);
    repeat (5) @(posedge clock);
    ctl_set <= LRSD_CTL_RECEIVE;
    repeat (10) begin
      @(negedge clock);
      if (frame_dropped === 1'b1) break;
    end
    check({frame_dropped, bus_pending, link_request_line}, 17'h00004);
    @(posedge clock);
    ctl_set <= LRSD_CTL_IDLE;
    repeat (20) @(posedge clock);
  endtask
  // Immediate request during receive, grant at packet end, then a bad header releases it.
  task automatic ack_grant();
    ctl_set <= LRSD_CTL_RECEIVE;
    @(posedge clock);
    send(LRSD_TYPE_IMMEDIATE, 3'h0, 4'h0, 8'h00);
    ctl_set <= LRSD_CTL_IDLE;
    repeat (10) begin
      @(negedge clock);
      if (ctl_oe === 1'b1) break;
    end
    check({ctl_oe, bus_pending}, 17'h00002);
    check(17'({ctl_out, ctl_drive}), 17'h00000);
    @(posedge clock);
    header_crc_bad <= 1'b1;
    @(negedge clock);
    check(17'(ctl_oe), 17'h00000);
    @(posedge clock);
    header_crc_bad <= 1'b0;
  endtask
  // The run needs about 380 cycles; the wide margin only catches a hang.
  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report();
  end
  initial begin
    // Reset held, control pair idle, short form asked for so it is used wherever legal.
    {rst, cmd_short, ctl_set} = 4'hC;
    {cmd_valid, cmd_accel_on, cycle_start_seen, bus_reset, header_crc_bad, read_answered} = 6'h00;
    {cmd_type, cmd_speed, cmd_addr, cmd_data} = 18'h00000;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    reg_requests();
    bus_requests();
    dropped_request();
    ack_grant();
    final_report();
  end
endmodule

`default_nettype wire
